// ---- inc/dct_regs.vh ----
// Register map, field positions, reset values, source codes and bus response codes of the dual countdown timer
`ifndef DCT_REGS_VH
`define DCT_REGS_VH
`define DCT_IDX_CTRL1     8'h24
`define DCT_IDX_CTRL2     8'h25
`define DCT_IDX_DATA1     8'h26
`define DCT_IDX_DATA2     8'h27
`define DCT_IDX_IRQ_STAT  8'h28
`define DCT_IDX_IRQ_MASK  8'h29
`define DCT_IDX_CNT1      8'h2a
`define DCT_IDX_CNT2      8'h2b
`define DCT_ADDR_W        10
`define DCT_B_EN          7
`define DCT_B_LOAD        6
`define DCT_B_SRC_HI      5
`define DCT_B_SRC_LO      4
`define DCT_B_EDGE        3
`define DCT_B_PS_HI       2
`define DCT_CTRL_RST      8'h40
`define DCT_DATA_RST      8'hff
`define DCT_SRC_SYS       2'b00
`define DCT_SRC_EXT       2'b01
`define DCT_SRC_CHAIN     2'b10
`define DCT_B_FLAG1       4
`define DCT_B_FLAG2       5
`define DCT_FLAG_MASK     8'h30
`define DCT_RESP_OKAY     2'b00
`define DCT_RESP_SLVERR   2'b10
`endif

// ---- src/dct_timer.v ----
// One 8-bit countdown timer with prescaler and immediate or deferred load
`include "dct_regs.vh"
module dct_timer (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // Control
  input  wire [7:0] ctrl_i,
  input  wire       tick_i,
  // Data register write
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  // State
  output wire [7:0] count_o,
  output wire [7:0] preload_o,
  output wire       ovf_o
);
  reg  [7:0] count_ff;
  reg  [7:0] preload_ff;
  reg  [6:0] pre_ff;
  reg        pending_ff;
  wire       enable;
  wire       load_now;
  wire [2:0] ps;
  wire       pre_done;
  wire       dec;

  assign enable   = ctrl_i[`DCT_B_EN];
  assign load_now = ctrl_i[`DCT_B_LOAD];
  assign ps       = ctrl_i[`DCT_B_PS_HI:0];
  assign pre_done = (ps == 3'h0) ? 1'b1 : ((pre_ff & ((7'h01 << ps) - 7'h01)) == ((7'h01 << ps) - 7'h01));
  assign dec      = enable & tick_i & pre_done;
  assign ovf_o     = dec & (count_ff == 8'h00);
  assign count_o   = count_ff;
  assign preload_o = preload_ff;

  // Prescaler advances on each selected source tick while enabled
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_ff <= 7'h00;
    end else if (enable & tick_i) begin
      pre_ff <= pre_done ? 7'h00 : pre_ff + 7'h01;
    end
  end

  // Counter, preload and deferred load
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff   <= `DCT_DATA_RST;
      preload_ff <= `DCT_DATA_RST;
      pending_ff <= 1'b0;
    end else begin
      if (wr_i) begin
        preload_ff <= wdata_i;
      end
      if (wr_i & load_now) begin
        count_ff   <= wdata_i;
        pending_ff <= 1'b0;
      end else if (ovf_o) begin
        count_ff   <= (wr_i | pending_ff) ? (wr_i ? wdata_i : preload_ff) : `DCT_DATA_RST;
        pending_ff <= 1'b0;
      end else begin
        if (dec) begin
          count_ff <= count_ff - 8'h01;
        end
        if (wr_i) begin
          pending_ff <= 1'b1;
        end
      end
    end
  end
endmodule // dct_timer

// ---- src/dct_top.v ----
// Dual 8-bit countdown timer with AXI4-Lite registers and interrupt
//
// Notes on behaviour
// - Timer one counts only while its control bit 7 is set.
// - Timer two counts only while its control bit 7 is set.
// - Timer one load mode 1: data write replaces the count at once.
// - Timer one load mode 0: data write waits, loads at next overflow.
// - Timer two uses the same load mode behaviour on its data register.
// - Timer one source 00 is the system clock.
// - Timer one other sources: external input, or timer two chaining 16 bits.
// - Timer two source 00 is the system clock.
// - Timer two source 10 is clocked by timer one, 16-bit chain.
// - Timer one bit 3 picks external edge: 1 falling, 0 rising.
// - Timer two bit 3 picks external edge: 1 falling, 0 rising.
// - Both data registers reset to all ones.
// - Each timer counts down 8 bits; chained pair counts 16 bits.
// - Overflow of timer one or two sets status bit 4 or 5.
// - Control registers reset with only the load-mode bit set.
//
// Register map, one byte register per word, byte address = index * 4
//   0x90 first timer control      0x94 second timer control
//   0x98 first timer data         0x9c second timer data
//   0xa0 overflow status          0xa4 overflow interrupt mask
//   0xa8 first preload, read only 0xac second preload, read only
// Control byte: bit 7 enable, bit 6 load mode, bits 5:4 source,
//   bit 3 external edge, bits 2:0 prescale power of two
//
// Design notes
// - Data registers read back the running count; the preloads read apart.
// - Timer one chained from timer two steps one cycle after that overflow,
//   so the chained pair settles one cycle after the low half wraps.
// - An overflow with no pending preload reloads all ones, a full period.
// - The external input is taken as synchronous; each level must stand
//   for at least one clock so that both edges are seen.
// - Prescale ps steps the count on every 2^ps selected ticks.
// - Status bits 4 and 5 are cleared by writing ones; a new overflow in the
//   same cycle wins over the clear.
// - The mask keeps bits 4 and 5 only; irq_o is a level.
// - A write to a mapped register with byte lane 0 strobe low is answered OKAY and ignored.
// - Addresses with bits 11:10 nonzero answer SLVERR and change nothing.
// - Write answer comes two cycles after both halves arrive together;
//   read data one cycle after the address. One of each at a time.
//
// Implementation choice: the AXI4-Lite slave port.
`include "dct_regs.vh"
module dct_top (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // External count input
  input  wire        external_count_input_i,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [11:0] s_axi_awaddr_i,
  input  wire [2:0]  s_axi_awprot_i,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  // AXI4-Lite write response
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  output wire [1:0]  s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  input  wire [11:0] s_axi_araddr_i,
  input  wire [2:0]  s_axi_arprot_i,
  // AXI4-Lite read data
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  // Interrupt
  output wire        irq_o
);
  // Software registers
  reg  [7:0]  ctrl1_ff;
  reg  [7:0]  ctrl2_ff;
  reg  [7:0]  stat_ff;
  reg  [7:0]  mask_ff;
  reg         ext_prev_ff;
  reg         ovf2_ff;
  // Register bus state
  reg         aw_got_ff;
  reg  [7:0]  aw_idx_ff;
  reg         w_got_ff;
  reg  [7:0]  w_data_ff;
  reg         w_lane_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;
  // Combinational selections
  reg  [31:0] nxt_rdata;
  reg         nxt_rhit;
  reg         tick1;
  reg         tick2;
  // Source ticks and timer wiring
  wire        ext_rise;
  wire        ext_fall;
  wire        ext_tick1;
  wire        ext_tick2;
  wire [1:0]  src1;
  wire [1:0]  src2;
  wire [7:0]  cnt1;
  wire [7:0]  cnt2;
  wire [7:0]  pre1;
  wire [7:0]  pre2;
  wire        ovf1;
  wire        ovf2;
  // Bus decode
  wire        wr_fire;
  wire        wr_d1;
  wire        wr_d2;
  wire [7:0]  ar_idx;
  wire [7:0]  aw_idx;

  // Edge detection on the synchronous external count input
  assign ext_rise = external_count_input_i & ~ext_prev_ff;
  assign ext_fall = ~external_count_input_i & ext_prev_ff;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= external_count_input_i;
    end
  end

  // Timer two overflow, registered for the timer one chain; a direct path
  // both ways would close a combinational loop through the source muxes
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf2_ff <= 1'b0;
    end else begin
      ovf2_ff <= ovf2;
    end
  end

  assign ext_tick1 = ctrl1_ff[`DCT_B_EDGE] ? ext_fall : ext_rise;
  assign ext_tick2 = ctrl2_ff[`DCT_B_EDGE] ? ext_fall : ext_rise;
  assign src1 = ctrl1_ff[`DCT_B_SRC_HI:`DCT_B_SRC_LO];
  assign src2 = ctrl2_ff[`DCT_B_SRC_HI:`DCT_B_SRC_LO];

  // Timer one source selection
  always @* begin
    case (src1)
      `DCT_SRC_SYS: tick1 = 1'b1;
      `DCT_SRC_EXT: tick1 = ext_tick1;
      // chained from timer two, one cycle behind
      default: tick1 = ovf2_ff;
    endcase
  end

  // Timer two source selection
  always @* begin
    case (src2)
      `DCT_SRC_SYS: tick2 = 1'b1;
      `DCT_SRC_CHAIN: tick2 = ovf1;
      default: tick2 = ext_tick2;
    endcase
  end

  // AXI write path: address and data taken in either order
  assign s_axi_awready_o = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready_o  = ~w_got_ff & ~bvalid_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign aw_idx  = aw_idx_ff;
  assign wr_d1   = wr_fire & w_lane_ff & (aw_idx == `DCT_IDX_DATA1);
  assign wr_d2   = wr_fire & w_lane_ff & (aw_idx == `DCT_IDX_DATA2);

  // Write halves, commit once both are held, then the response
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      w_got_ff  <= 1'b0;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `DCT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_got_ff <= 1'b1;
        aw_idx_ff <= (s_axi_awaddr_i[11:10] == 2'b00) ? s_axi_awaddr_i[9:2] : 8'h00;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata_i[7:0];
        w_lane_ff <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= ((aw_idx >= `DCT_IDX_CTRL1) && (aw_idx <= `DCT_IDX_CNT2)) ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control, mask and status registers
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // control resets to load mode only
      ctrl1_ff <= `DCT_CTRL_RST;
      ctrl2_ff <= `DCT_CTRL_RST;
      mask_ff  <= 8'h00;
      stat_ff  <= 8'h00;
    end else begin
      if (wr_fire & w_lane_ff & (aw_idx == `DCT_IDX_CTRL1)) begin
        ctrl1_ff <= w_data_ff;
      end
      if (wr_fire & w_lane_ff & (aw_idx == `DCT_IDX_CTRL2)) begin
        ctrl2_ff <= w_data_ff;
      end
      if (wr_fire & w_lane_ff & (aw_idx == `DCT_IDX_IRQ_MASK)) begin
        mask_ff <= w_data_ff & `DCT_FLAG_MASK;
      end
      // overflow sets flag, set wins over clear
      stat_ff <= ((wr_fire & w_lane_ff & (aw_idx == `DCT_IDX_IRQ_STAT)) ? (stat_ff & ~w_data_ff) : stat_ff)
                 | {2'b00, ovf2, ovf1, 4'h0};
    end
  end

  // Level interrupt from unmasked overflow flags
  assign irq_o = |(stat_ff & mask_ff);

  // AXI read path
  assign ar_idx          = (s_axi_araddr_i[11:10] == 2'b00) ? s_axi_araddr_i[9:2] : 8'h00;
  assign s_axi_arready_o = ~rvalid_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;

  // Read data selection; data registers show the running count
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rhit  = 1'b1;
    case (ar_idx)
      `DCT_IDX_CTRL1:    nxt_rdata[7:0] = ctrl1_ff;
      `DCT_IDX_CTRL2:    nxt_rdata[7:0] = ctrl2_ff;
      `DCT_IDX_DATA1:    nxt_rdata[7:0] = cnt1;
      `DCT_IDX_DATA2:    nxt_rdata[7:0] = cnt2;
      `DCT_IDX_IRQ_STAT: nxt_rdata[7:0] = stat_ff;
      `DCT_IDX_IRQ_MASK: nxt_rdata[7:0] = mask_ff;
      `DCT_IDX_CNT1:     nxt_rdata[7:0] = pre1;
      `DCT_IDX_CNT2:     nxt_rdata[7:0] = pre2;
      default:           nxt_rhit = 1'b0;
    endcase
  end

  // Read answer: data and response stand until rready
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `DCT_RESP_OKAY;
    end else if (s_axi_arvalid_i & s_axi_arready_o) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rhit ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
    end else if (rvalid_ff & s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  // two 8-bit timers, chained through overflow ticks
  dct_timer u_timer_one (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ctrl_i    (ctrl1_ff),
    .tick_i    (tick1),
    .wr_i      (wr_d1),
    .wdata_i   (w_data_ff),
    .count_o   (cnt1),
    .preload_o (pre1),
    .ovf_o     (ovf1)
  );

  dct_timer u_timer_two (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ctrl_i    (ctrl2_ff),
    .tick_i    (tick2),
    .wr_i      (wr_d2),
    .wdata_i   (w_data_ff),
    .count_o   (cnt2),
    .preload_o (pre2),
    .ovf_o     (ovf2)
  );
endmodule // dct_top

// ---- testbench/dct_props.sv ----
// Bus answer properties of the dual countdown timer
module dct_props (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // Write channels
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  // Read channels
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Transfers taken by the register slave
  sequence s_wtake;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rtake;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // Answers, holds and refusals
  a_wr_answer: assert property (s_wtake |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write answer off time");
  a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  a_aw_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answering");
  a_rd_answer: assert property (s_rtake |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answering");
  a_rd_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read upper bits set");
  a_bad_addr: assert property (s_rtake ##0 s_axi_araddr_i[11:10] != 2'h0 |=> s_axi_rresp_o == 2'b10)
    else $error("unmapped read not refused");
endmodule // dct_props

bind dct_top dct_props dct_props_i (.sys_clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o);

// ---- testbench/dct_ext_src.sv ----
// External count input model: trains of clean pulses
module dct_ext_src (
  // Clock
  input  wire logic sys_clk_i,
  // Count pin
  output logic      ext_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin rests low between trains
  initial ext_o = 1'b0;
  // Each level stands four cycles so every edge is seen
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk_i);
      ext_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      ext_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule // dct_ext_src

// ---- testbench/testbench.sv ----
// Self-checking bench of the dual countdown timer
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and answers
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, q;
  logic [1:0]  qr, qb;
  wire         awr, wrd, bv, arr, rv, irq, ext;
  wire [1:0]   br, rr;
  wire [31:0]  rdt;
  int          err_count = 0;
  int          check_count = 0;
  dct_top dct_top_i (.sys_clk_i(clk), .rst_i(rst), .external_count_input_i(ext),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .irq_o(irq));
  dct_ext_src dct_ext_src_i (.sys_clk_i(clk), .ext_o(ext));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus write; handshakes judged mid-cycle, released after the edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    logic ta, tw, tb;
    @(posedge clk);
    awv <= 1; wv <= 1; awa <= a; wd <= {24'h0, d}; bre <= 1;
    tb = 0;
    for (n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awv && awr; tw = wv && wrd; tb = bv;
      qb = br;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) bre <= 0;
    end
    if (!tb) begin err_count++; conclude; end
  endtask
  // Bus read into q and qr
  task automatic rd(input logic [11:0] a);
    int n;
    logic ta, tr;
    @(posedge clk);
    arv <= 1; ara <= a; rre <= 1;
    tr = 0;
    for (n = 0; n < 50 && !tr; n++) begin
      @(negedge clk);
      ta = arv && arr; tr = rv; q = rdt; qr = rr;
      @(posedge clk);
      if (ta) arv <= 0;
      if (tr) rre <= 0;
    end
    if (!tr) begin err_count++; conclude; end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    `CHK(q, {24'h0, e})
  endtask
  task automatic t_reset;
    rchk(12'h090, 8'h40);
    rchk(12'h094, 8'h40);
    rchk(12'h098, 8'hff);
    rchk(12'h09c, 8'hff);
    rd(12'h490);
    `CHK(qr, 2'b10)
    wr(12'h498, 8'h12);
    `CHK(qb, 2'b10)
    rchk(12'h098, 8'hff);
  endtask
  // Edge, prescale and enable per timer on the external input
  task automatic t_ext;
    logic [7:0] c [4] = '{8'hd0, 8'hd8, 8'hd1, 8'h50};
    int p [4] = '{5, 3, 4, 3};
    int d [4] = '{5, 3, 2, 0};
    for (int t = 0; t < 2; t++)
      for (int i = 0; i < 4; i++) begin
        wr(12'(12'h090 + 4 * t), c[i]);
        wr(12'(12'h098 + 4 * t), 8'h40);
        dct_ext_src_i.pulses(p[i]);
        rchk(12'(12'h098 + 4 * t), 8'(8'h40 - d[i]));
      end
  endtask
  // System clock runs, then holds once disabled; one timer at a time
  task automatic t_sys;
    logic [31:0] v;
    for (int t = 0; t < 2; t++) begin
      wr(12'(12'h090 + 4 * t), 8'hc0);
      rd(12'(12'h098 + 4 * t));
      v = q;
      rd(12'(12'h098 + 4 * t));
      `CHK(q == v, 1'b0)
      wr(12'(12'h090 + 4 * t), 8'h40);
      rd(12'(12'h098 + 4 * t));
      v = q;
      rd(12'(12'h098 + 4 * t));
      `CHK(q, v)
    end
  endtask
  // Deferred load at overflow, status flag and interrupt
  task automatic t_defer;
    logic [7:0] b;
    wr(12'h0a0, 8'h30);
    for (int t = 0; t < 2; t++) begin
      b = 8'(8'h10 << t);
      wr(12'(12'h090 + 4 * t), 8'h50);
      wr(12'(12'h098 + 4 * t), 8'h02);
      wr(12'(12'h090 + 4 * t), 8'h90);
      wr(12'(12'h098 + 4 * t), 8'h07);
      rchk(12'(12'h0a8 + 4 * t), 8'h07);
      rchk(12'(12'h098 + 4 * t), 8'h02);
      dct_ext_src_i.pulses(3);
      rchk(12'(12'h098 + 4 * t), 8'h07);
      rchk(12'h0a0, b);
      `CHK(irq, 1'b0)
      wr(12'h0a4, b);
      `CHK(irq, 1'b1)
      wr(12'h0a0, b);
      `CHK(irq, 1'b0)
      wr(12'h0a4, 8'h00);
    end
  endtask
  // Cascade both ways: the chained timer steps once per overflow of the other
  task automatic t_chain;
    wr(12'h0a0, 8'h30);
    wr(12'h090, 8'h50);
    wr(12'h098, 8'h01);
    wr(12'h094, 8'he0);
    wr(12'h09c, 8'h05);
    wr(12'h090, 8'hd0);
    dct_ext_src_i.pulses(3);
    rchk(12'h098, 8'hfe);
    rchk(12'h09c, 8'h04);
    wr(12'h094, 8'h50);
    wr(12'h09c, 8'h00);
    wr(12'h090, 8'he0);
    wr(12'h098, 8'h09);
    wr(12'h094, 8'hd0);
    dct_ext_src_i.pulses(2);
    rchk(12'h09c, 8'hfe);
    rchk(12'h098, 8'h08);
    rchk(12'h0a0, 8'h30);
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ext;
    t_sys;
    t_defer;
    t_chain;
    conclude;
  end
endmodule // testbench
